//--- core/rbs_sequencer.sv
// Reset and brown-out sequencer: merges all reset sources into one core reset.
// Assumes monitor, pin and configuration inputs synchronous to pclk, and an APB master.
`timescale 1ns/1ps

// Behaviour
// - Six reset sources: power-on, brown-out, low-power brown-out, pin, watchdog, program exit.
// - Core stays in reset while the supply is below its minimum level.
// - Power-up timer gives a 64 ms timeout after power-on or brown-out.
// - Core reset stays asserted the whole time the timer counts.
// - Timer runs when the active-low disable bit is zero, skipped when one.
// - Timer starts only once power-on and brown-out conditions have both cleared.
// - Core held in reset while the supply is below the selected threshold.
// - Two-bit mode: 11 always on, 10 off in Sleep, 01 software, 00 off.
// - Brown-out only after the dip outlasts the filter time; shorter dips ignored.
// - Mode 11: start waits for ready and supply; Sleep protected; wake not delayed.
// - Mode 10: off in Sleep; start waits ready and supply; wake waits ready.
// - Mode 01: software bit switches brown-out; start-up does not wait.
// - Software mode protects once circuit is ready; status shows circuit; Sleep irrelevant.
// - With brown-out off (mode 00, or mode 01 with the bit clear), release and wake-up proceed at once.
// - Forced-on modes hold start-up until ready; ready set before execution.
// - Software enable bit acts only in mode 01; one enables, zero disables.
// - Ready status reads one while the circuit is active, zero otherwise.
// - Low-power brown-out request is ORed into the common brown-out signal.
// - With timer expired, execution starts 10 cycles after pin release.
module rbs_sequencer
	import rbs_pkg::*;
#(
	parameter int unsigned PU_CNT = PU_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Configuration word and supply monitors
	input  wire rbs_cfg_s    cfg,
	input  wire rbs_mon_s    mon,
	// Other reset sources and power state
	input  wire logic        ext_reset_pin_n,
	input  wire logic        watchdog_timeout,
	input  wire logic        prog_mode_exit,
	input  wire logic        sleep_active,
	// Outputs to the core and the analogue monitor
	output logic             core_reset_n,
	output logic             wake_permit,
	output logic             bor_circuit_enable,
	output logic             brownout_level_select
);

	rbs_state_e        state_q;
	rbs_state_e        state_d;
	logic [PU_W-1:0]   pu_cnt_q;
	logic [3:0]        dly_cnt_q;
	logic              sbor_q;
	logic [4:0]        flags_q;
	logic              core_reset_n_q;
	logic              wake_permit_q;
	logic              bor_en_q;
	logic              level_sel_q;
	logic [31:0]       prdata_q;
	logic              pready_q;
	logic              pslverr_q;
	logic              bor_filt;
	logic              pin_low_filt;
	logic              bor_enabled;
	logic              brownout_ready;
	logic              bor_req;
	logic              hard_req;
	logic              pu_done;
	logic              start_wait;
	logic              pin_hold;
	logic              acc;
	logic              fin;
	logic              wr_status;

	assign prdata                = prdata_q;
	assign pready                = pready_q;
	assign pslverr               = pslverr_q;
	assign core_reset_n          = core_reset_n_q;
	assign wake_permit           = wake_permit_q;
	assign bor_circuit_enable    = bor_en_q;
	assign brownout_level_select = level_sel_q;

	// Brown-out enable by mode; the software bit counts only in mode 01.
	always_comb begin
		unique case (cfg.brownout_mode_select)
			BMODE_ALWAYS_ON: bor_enabled = 1'b1;
			BMODE_NO_SLEEP:  bor_enabled = !sleep_active;
			BMODE_SOFTWARE:  bor_enabled = sbor_q;
			BMODE_OFF:       bor_enabled = 1'b0;
		endcase
	end

	// Protection only acts once the circuit reports ready.
	assign brownout_ready = bor_enabled && mon.bor_circuit_ready;

	rbs_filter #(
		.CNT (BOR_FILTER_CYCLES),
		.W   (8)
	) u_bor_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (mon.bor_below && brownout_ready),
		.level_q (bor_filt)
	);

	rbs_filter #(
		.CNT (PIN_FILTER_CYCLES),
		.W   (8)
	) u_pin_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (cfg.external_reset_pin_en && !ext_reset_pin_n),
		.level_q (pin_low_filt)
	);

	assign bor_req  = bor_filt || (cfg.low_power_brownout_en && mon.low_power_brownout);
	// Programming exit behaves as a fresh power-on.
	assign hard_req = mon.por_low || bor_req || prog_mode_exit;
	assign pu_done  = pu_cnt_q == PU_W'(PU_CNT - 1);
	// Only the two hardware-on modes hold start-up for the circuit and supply.
	assign start_wait = cfg.brownout_mode_select[1]
		&& (!mon.bor_circuit_ready || mon.bor_below);
	assign pin_hold = pin_low_filt || watchdog_timeout;

	always_comb begin
		state_d = state_q;
		if (hard_req) begin
			state_d = ST_HOLD;
		end else begin
			unique case (state_q)
				ST_HOLD: begin
					if (!cfg.power_up_timer_disable_n) begin
						state_d = ST_TIMER;
					end else begin
						state_d = ST_BOR_WAIT;
					end
				end
				ST_TIMER: begin
					if (pu_done) begin
						state_d = ST_BOR_WAIT;
					end
				end
				ST_BOR_WAIT: begin
					if (!start_wait) begin
						state_d = ST_PIN_WAIT;
					end
				end
				ST_PIN_WAIT: begin
					if (!pin_hold) begin
						state_d = ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (pin_hold) begin
						state_d = ST_PIN_WAIT;
					end else if (dly_cnt_q == RELEASE_CYCLES - 4'h1) begin
						state_d = ST_RUN;
					end
				end
				ST_RUN: begin
					if (pin_hold) begin
						state_d = ST_PIN_WAIT;
					end
				end
				default: state_d = ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// The timer runs on regardless of the pin, so a long pin hold uses it up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_cnt_q <= '0;
		end else if (state_q == ST_TIMER && !hard_req) begin
			pu_cnt_q <= pu_cnt_q + PU_W'(1);
		end else begin
			pu_cnt_q <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_q <= '0;
		end else if (state_q == ST_DELAY && state_d == ST_DELAY) begin
			dly_cnt_q <= dly_cnt_q + 4'h1;
		end else begin
			dly_cnt_q <= '0;
		end
	end

	// Released only on the clock edge that enters the run state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n_q <= 1'b0;
		end else begin
			core_reset_n_q <= state_d == ST_RUN;
		end
	end

	// Only mode 10 holds wake-up back until the circuit is ready.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_permit_q <= 1'b0;
		end else begin
			wake_permit_q <= cfg.brownout_mode_select != BMODE_NO_SLEEP
				|| mon.bor_circuit_ready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bor_en_q    <= 1'b0;
			level_sel_q <= 1'b0;
		end else begin
			bor_en_q    <= bor_enabled;
			level_sel_q <= cfg.brownout_level_select;
		end
	end

	// Writes land on the edge that completes the transfer, where pready is sampled high.
	assign acc       = psel && penable && !pready_q;
	assign fin       = psel && penable && pready_q;
	assign wr_status = fin && pwrite && paddr == REG_STATUS_OFS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sbor_q <= CTRL_SBOR_RST;
		end else if (fin && pwrite && paddr == REG_CTRL_OFS) begin
			sbor_q <= pwdata[CTRL_SBOR_BIT];
		end
	end

	// Cause flags: a new event in the clearing cycle stays set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= ST_FLAGS_RST;
		end else begin
			flags_q <= (flags_q & ~({5{wr_status}} & pwdata[ST_PROG_BIT:ST_POR_BIT]))
				| {prog_mode_exit, pin_low_filt, watchdog_timeout, bor_req, mon.por_low};
		end
	end

	// One wait state: the answer is registered so all outputs come from flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc && paddr != REG_CTRL_OFS && paddr != REG_STATUS_OFS;
			prdata_q  <= 32'h0000_0000;
			if (acc && !pwrite && paddr == REG_CTRL_OFS) begin
				prdata_q[CTRL_SBOR_BIT] <= sbor_q;
			end else if (acc && !pwrite && paddr == REG_STATUS_OFS) begin
				prdata_q[ST_READY_BIT]            <= brownout_ready;
				prdata_q[ST_PROG_BIT:ST_POR_BIT]  <= flags_q;
				prdata_q[ST_TIMER_BIT]            <= state_q == ST_TIMER;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_por_holds_reset : assert property (mon.por_low |=> !core_reset_n_q)
		else $error("core left reset while supply below minimum");

	a_timer_holds_reset : assert property (state_q == ST_TIMER |-> !core_reset_n_q)
		else $error("core out of reset while timer counts");

	a_timer_full_count : assert property (state_q == ST_TIMER && !hard_req
		&& state_d == ST_BOR_WAIT |-> pu_cnt_q == PU_W'(PU_CNT - 1))
		else $error("power-up timer ended early");

	// The presetn term skips the attempt on the releasing edge, while the state is still held.
	a_timer_start : assert property (presetn && state_q == ST_HOLD && !hard_req
		|=> state_q == (cfg.power_up_timer_disable_n ? ST_BOR_WAIT : ST_TIMER))
		else $error("timer enable not obeyed");

	a_timer_after_release : assert property (state_q == ST_TIMER |-> !$past(hard_req))
		else $error("timer running during power-on or brown-out");

	a_bor_holds_reset : assert property (bor_req |=> !core_reset_n_q && state_q == ST_HOLD)
		else $error("brown-out did not reset the core");

	a_mode_off : assert property (cfg.brownout_mode_select == BMODE_OFF |-> !bor_enabled)
		else $error("brown-out active in off mode");

	a_sw_enable : assert property (cfg.brownout_mode_select == BMODE_SOFTWARE
		|-> bor_enabled == sbor_q)
		else $error("software enable not followed in mode 01");

	a_no_start_wait : assert property (state_q == ST_BOR_WAIT && !hard_req
		&& !cfg.brownout_mode_select[1] |=> state_q != ST_BOR_WAIT)
		else $error("start-up delayed in software or off mode");

	a_start_waits : assert property (state_q == ST_BOR_WAIT && cfg.brownout_mode_select[1]
		&& !mon.bor_circuit_ready |=> state_q inside {ST_BOR_WAIT, ST_HOLD})
		else $error("start-up did not wait for brown-out ready");

	a_wake_hold : assert property (cfg.brownout_mode_select == BMODE_NO_SLEEP
		&& !mon.bor_circuit_ready |=> !wake_permit_q)
		else $error("wake-up allowed before brown-out ready");

	a_wake_free : assert property (presetn && cfg.brownout_mode_select == BMODE_ALWAYS_ON
		|=> wake_permit_q)
		else $error("wake-up delayed in always-on mode");

	a_lp_merge : assert property (cfg.low_power_brownout_en && mon.low_power_brownout
		|=> !core_reset_n_q)
		else $error("low-power brown-out did not reset");

	a_release_delay : assert property ($rose(core_reset_n_q)
		|-> $past(state_q, 2) == ST_DELAY && $past(dly_cnt_q) == RELEASE_CYCLES - 4'h1)
		else $error("release not 10 cycles after pin");

	a_run_only_clear : assert property (core_reset_n_q
		|-> !$past(hard_req) && !$past(pin_hold))
		else $error("core released with a request active");

	c_full_start : cover property (state_q == ST_TIMER ##[1:1000] $rose(core_reset_n_q));
	c_wdt_reset : cover property (core_reset_n_q && watchdog_timeout ##1 !core_reset_n_q);
	c_bor_in_run : cover property (core_reset_n_q && bor_req);
	c_pin_past_timer : cover property (state_q == ST_PIN_WAIT && pin_low_filt [*8]);

endmodule // rbs_sequencer

//--- core/rbs_pkg.sv
// Constants, field layouts and carrier types of the reset and brown-out sequencer.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
package rbs_pkg;

	// Clock rate in MHz.
	localparam int unsigned CLK_MHZ = 125;

	// Power-up timer nominal timeout.
	localparam int unsigned PU_TIME_MS = 64;
	localparam int unsigned PU_CYCLES  = PU_TIME_MS * CLK_MHZ * 1000;
	localparam int unsigned PU_W       = 23;

	// Supply dip filter; the figure is a plain default, since no value is fixed.
	localparam int unsigned BOR_FILTER_NS     = 1000;
	localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_NS * CLK_MHZ + 999) / 1000;

	// External pin noise filter, a least time, rounded up.
	localparam int unsigned PIN_FILTER_NS     = 200;
	localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;

	// Cycles from pin release to execution once the timer has run out.
	localparam logic [3:0] RELEASE_CYCLES = 4'hA;

	// Brown-out mode encodings.
	localparam logic [1:0] BMODE_ALWAYS_ON = 2'h3;
	localparam logic [1:0] BMODE_NO_SLEEP  = 2'h2;
	localparam logic [1:0] BMODE_SOFTWARE  = 2'h1;
	localparam logic [1:0] BMODE_OFF       = 2'h0;

	// Register byte offsets.
	localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
	localparam logic [11:0] REG_STATUS_OFS = 12'h004;

	// Control register fields and reset value.
	localparam int unsigned CTRL_SBOR_BIT = 0;
	localparam logic        CTRL_SBOR_RST = 1'h1;

	// Status register fields; bits 1 to 5 are sticky and cleared by writing one.
	localparam int unsigned ST_READY_BIT = 0;
	localparam int unsigned ST_POR_BIT   = 1;
	localparam int unsigned ST_BOR_BIT   = 2;
	localparam int unsigned ST_WDT_BIT   = 3;
	localparam int unsigned ST_PIN_BIT   = 4;
	localparam int unsigned ST_PROG_BIT  = 5;
	localparam int unsigned ST_TIMER_BIT = 6;
	localparam logic [4:0]  ST_FLAGS_RST = 5'h01;

	// Configuration word bits that steer the sequencer.
	typedef struct packed {
		logic       power_up_timer_disable_n;
		logic [1:0] brownout_mode_select;
		logic       brownout_level_select;
		logic       low_power_brownout_en;
		logic       external_reset_pin_en;
	} rbs_cfg_s;

	// Analogue supply monitor outputs.
	typedef struct packed {
		logic por_low;
		logic bor_below;
		logic low_power_brownout;
		logic bor_circuit_ready;
	} rbs_mon_s;

	// Sequencer states, Gray coded along the start-up path.
	typedef enum logic [2:0] {
		ST_HOLD     = 3'h0,
		ST_TIMER    = 3'h1,
		ST_BOR_WAIT = 3'h3,
		ST_PIN_WAIT = 3'h2,
		ST_DELAY    = 3'h6,
		ST_RUN      = 3'h7
	} rbs_state_e;

endpackage

//--- core/rbs_filter.sv
// Level filter: the output rises only after the input has stayed high for CNT cycles.
// Assumes the input is synchronous to pclk.
`timescale 1ns/1ps
module rbs_filter
	import rbs_pkg::*;
#(
	parameter int unsigned CNT = 4,
	parameter int unsigned W   = 8
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Filtered level
	input  wire logic level,
	output logic      level_q
);

	logic [W-1:0] cnt_q;

	// Any low cycle restarts the count, so short pulses never pass.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (!level) begin
			cnt_q <= '0;
		end else if (cnt_q != W'(CNT)) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level && (cnt_q == W'(CNT));
		end
	end

	a_filter_length : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(level_q) |-> $past(cnt_q) == W'(CNT))
		else $error("filter output rose before the full count");

	a_filter_drop : assert property (@(posedge pclk) disable iff (!presetn)
		!level |=> !level_q)
		else $error("filter output held after input fell");

endmodule // rbs_filter

//--- tb/rbs_monitor_model.sv
// Behavioural model of the analogue supply monitors beside the sequencer.
// Assumes the bench sets supply conditions just after pclk edges.
`timescale 1ns/1ps
module rbs_monitor_model
	import rbs_pkg::*;
#(
	parameter int unsigned READY_DLY = 4
) (
	// Clock
	input  wire logic pclk,
	// Supply conditions from the bench
	input  wire logic supply_low,
	input  wire logic supply_dip,
	input  wire logic lp_trip,
	// Circuit control from the sequencer
	input  wire logic circuit_en,
	// Monitor outputs
	output rbs_mon_s  mon
);
	int unsigned ready_cnt_q = 0;
	logic        toggle_q    = 1'b0;
	logic        rdy;

	// The comparator needs a few cycles to settle after it is switched on.
	always_ff @(posedge pclk) begin
		if (!circuit_en)
			ready_cnt_q <= 0;
		else if (ready_cnt_q < READY_DLY)
			ready_cnt_q <= ready_cnt_q + 1;
	end

	always_ff @(posedge pclk) begin
		toggle_q <= !toggle_q;
	end

	assign rdy = (ready_cnt_q >= READY_DLY);
	// An unsettled comparator gives no trustworthy level, so its output wanders.
	assign mon = {supply_low, (rdy ? supply_dip : toggle_q), lp_trip, rdy};
endmodule // rbs_monitor_model

//--- tb/tb_rbs_sequencer.sv
// Self-checking bench for the reset and brown-out sequencer.
// Assumes the monitor model in rbs_monitor_model.sv and a 125 MHz pclk.
`timescale 1ns/1ps
module tb_rbs_sequencer
	import rbs_pkg::*;
;
	localparam int unsigned PU_SIM = 20;
	localparam int          FLAG[4]  = '{ST_POR_BIT, ST_PROG_BIT, ST_WDT_BIT, ST_BOR_BIT};

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	rbs_cfg_s    cfg     = 6'h23;
	rbs_mon_s    mon;
	logic        pin_n   = 1'b1;
	logic        wdt     = 1'b0;
	logic        prog    = 1'b0;
	logic        sleep   = 1'b0;
	logic        low     = 1'b0;
	logic        dip     = 1'b0;
	logic        lp      = 1'b0;
	logic        core_n;
	logic        wake;
	logic        circ_en;
	logic        lvl;
	int          num_errors = 0;
	int          checks     = 0;
	int          cyc        = 0;

	rbs_sequencer #(.PU_CNT(PU_SIM)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg), .mon(mon),
		.ext_reset_pin_n(pin_n), .watchdog_timeout(wdt), .prog_mode_exit(prog),
		.sleep_active(sleep), .core_reset_n(core_n), .wake_permit(wake),
		.bor_circuit_enable(circ_en), .brownout_level_select(lvl)
	);

	rbs_monitor_model i_mon (
		.pclk(pclk), .supply_low(low), .supply_dip(dip), .lp_trip(lp),
		.circuit_en(circ_en), .mon(mon)
	);

	initial begin
		forever #4 pclk = ~pclk;
	end

	task automatic results();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// The whole run takes about a thousand cycles; a hang stops well beyond that.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(what, exp, rd);
		chk("slave error", 32'h0, e);
	endtask

	task automatic rst(input logic [1:0] m, input logic tdis, input logic d);
		@(posedge pclk);
		presetn <= 1'b0;
		cfg.brownout_mode_select     <= m;
		cfg.power_up_timer_disable_n <= tdis;
		dip <= d;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Counts edges after the current one until the core leaves reset.
	task automatic rel(output int n);
		n = 0;
		while (core_n !== 1'b1 && n < 400) begin
			@(posedge pclk);
			#1;
			n++;
		end
	endtask

	initial begin
		int          n;
		logic [31:0] rd;
		logic        err;
		logic        exp_en;
		rst(BMODE_OFF, 1'b1, 1'b0);
		rel(n);
		chk("release cycles", 32'hD, n);
		rdchk("ctrl reset", REG_CTRL_OFS, 32'h1);
		rdchk("status reset", REG_STATUS_OFS, 32'h2);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, err);
		wr(REG_STATUS_OFS, 32'h3E);
		rdchk("status cleared", REG_STATUS_OFS, 32'h0);
		$display("test registers done");

		rst(BMODE_OFF, 1'b0, 1'b0);
		rdchk("timer status", REG_STATUS_OFS, 32'h42);
		// The read above spends four of the edges that lead up to release.
		rel(n);
		chk("timer release", 32'hD + PU_SIM - 32'h4, n);
		rst(BMODE_ALWAYS_ON, 1'b1, 1'b1);
		repeat (60) @(posedge pclk);
		#1;
		chk("start held", 32'h0, core_n);
		@(posedge pclk);
		dip <= 1'b0;
		rel(n);
		chk("start freed", 32'h1, core_n);
		rst(BMODE_SOFTWARE, 1'b1, 1'b1);
		rel(n);
		chk("soft release", 32'hD, n);
		@(posedge pclk);
		dip <= 1'b0;
		rdchk("soft ready", REG_STATUS_OFS, 32'h3);
		$display("test start-up done");

		for (int i = 0; i < 4; i++) begin
			wr(REG_STATUS_OFS, 32'h3E);
			@(posedge pclk);
			{lp, wdt, prog, low} <= 4'h1 << i;
			repeat (3) @(posedge pclk);
			{lp, wdt, prog, low} <= 4'h0;
			#1;
			chk("core held", 32'h0, core_n);
			rel(n);
			chk("core freed", 32'h1, core_n);
			rdchk("cause flag", REG_STATUS_OFS, 32'h1 | (32'h1 << FLAG[i]));
		end
		wr(REG_STATUS_OFS, 32'h3E);
		@(posedge pclk);
		pin_n <= 1'b0;
		repeat (40) @(posedge pclk);
		pin_n <= 1'b1;
		rel(n);
		chk("pin delay", 32'h1, n >= 10 && n <= 10 + PIN_FILTER_CYCLES + 3);
		rdchk("pin flag", REG_STATUS_OFS, 32'h11);
		$display("test sources done");

		wr(REG_STATUS_OFS, 32'h3E);
		@(posedge pclk);
		cfg.brownout_mode_select <= BMODE_ALWAYS_ON;
		dip <= 1'b1;
		repeat (100) @(posedge pclk);
		dip <= 1'b0;
		#1;
		chk("short dip", 32'h1, core_n);
		@(posedge pclk);
		dip <= 1'b1;
		repeat (130) @(posedge pclk);
		#1;
		chk("long dip", 32'h0, core_n);
		@(posedge pclk);
		dip <= 1'b0;
		rel(n);
		rdchk("dip flag", REG_STATUS_OFS, 32'h5);
		$display("test filter done");

		wr(REG_STATUS_OFS, 32'h3E);
		for (int k = 0; k < 16; k++) begin
			wr(REG_CTRL_OFS, {31'h0, k[2]});
			@(posedge pclk);
			cfg.brownout_mode_select  <= k[1:0];
			cfg.brownout_level_select <= k[0];
			sleep <= k[3];
			repeat (10) @(posedge pclk);
			#1;
			exp_en = (k[1:0] == BMODE_ALWAYS_ON) || (k[1:0] == BMODE_NO_SLEEP && !k[3])
				|| (k[1:0] == BMODE_SOFTWARE && k[2]);
			chk("circuit enable", {31'h0, exp_en}, circ_en);
			chk("wake permit", {31'h0, k[1:0] != BMODE_NO_SLEEP || exp_en}, wake);
			chk("level select", {31'h0, k[0]}, lvl);
			rdchk("ready status", REG_STATUS_OFS, {31'h0, exp_en});
		end
		$display("test modes done");
		results();
	end
endmodule // tb_rbs_sequencer
